// file: src/hwmon_regs.v
// Monitoring result, offset and control registers behind the management bus port
//
// What this block does
// [RL1] Duty register writable only in manual mode, start set, lock clear.
// [RL2] Lock freezes lock and start bits; override bit stays writable.
// [RL3] Reading interrupt status clears it only when no event is still active.
// [RL4] Interrupt output enable bit is always writable.
// [RL5] Shutdown blocks all registers except low three function bits and config.
// [RL6] Reserved PWM option bits are plain storage with no effect.
// [RL7] Undefined addresses read zero; writes there are dropped silently.
// [RL8] Test register resets to zero, writable even when locked; host must not write.
// [RL9] Three temperature offset registers become read-only under lock.
// [RL10] Ambient offset, signed, reset zero, added to internal sensor result.
// [RL11] Remote offsets, signed, reset zero, added to remote results 2 and 1.
// [RL12] Voltage nominal reads C0h, maximum FFh, zero volts 00h.
// [RL13] Voltage results at 20h-24h: 2.5V, core, 3.3V, 5V, 12V.
// [RL14] Results refresh at least four times a second; writes ignored.
// [RL15] Temperatures are signed whole degrees from -127 to +127.
// [RL16] Faulty or absent remote diode reports 80h.
// [RL17] Temperature results: remote 1, ambient, remote 2 in address order.
// [RL18] Zone 1 remote 1, zone 2 ambient, zone 3 remote 2.
// [RL19] Lock stays set until reset once written.
`include "hwmon_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module hwmon_regs #(
  parameter REFRESH_CYCLES = `REFRESH_CYC,  // Result refresh period in cycles
  parameter NUM_EVT        = 8              // Event inputs per status register
) (
  input  wire                 sys_clk,        // 40 MHz clock

  input  wire                 rst,            // Synchronous reset, high

  input  wire                 reg_wr,         // Register write strobe

  input  wire                 reg_rd,         // Register read strobe

  input  wire [7:0]           reg_addr,       // Register address

  input  wire [7:0]           reg_wdata,      // Write data

  output reg  [7:0]           reg_rdata,      // Read data, valid cycle after reg_rd

  input  wire [39:0]          volt_raw,       // Five scaled voltage codes, 2.5V in low byte

  input  wire [23:0]          temp_raw,       // Remote1, ambient, remote2 raw temps

  input  wire [1:0]           diode_fault,    // Remote1, remote2 diode fault

  input  wire [2:0]           manual_mode,    // Per fan manual mode

  input  wire [NUM_EVT-1:0]   evt1_in,        // Active events for status 1

  input  wire [NUM_EVT-1:0]   evt2_in,        // Active events for status 2

  output reg  [23:0]          zone_temp,      // Zone 1..3 temps for fan control

  output reg  [23:0]          manual_duty,    // Host duty per fan

  output reg                  start_q,        // Monitoring started

  output reg                  lock_q,         // Configuration locked

  output reg                  override_q,     // Fan override

  output reg                  irq_output_enable, // Interrupt pin enable

  output reg                  low_power_select,  // Low power mode select

  output reg  [7:0]           factory_test_q  // Test register contents
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

  // Saturating signed add, clamps into -127..+127 so 80h stays the error code
  function [7:0] sat_add;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {a[7], a} + {b[7], b};
      if (!s[8] && s[7])
        sat_add = `TEMP_MAX;
      else if (s[8] && (!s[7] || s[7:0] == `TEMP_ERR))
        sat_add = `TEMP_MIN;
      else
        sat_add = s[7:0];
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// State

  reg  [7:0]          ofs_amb_q;

  reg  [7:0]          ofs_rmt2_q;

  reg  [7:0]          ofs_rmt1_q;

  reg  [39:0]         volt_q;

  reg  [23:0]         temp_q;

  reg  [7:0]          pwmopt_q [0:2];

  reg  [2:0]          sfr_low_q;

  reg  [7:0]          sfr_high_q;

  reg  [7:0]          config_q;

  reg  [NUM_EVT-1:0]  istat1_q;

  reg  [NUM_EVT-1:0]  istat2_q;

  reg  [31:0]         refresh_cnt_q;

  reg  [7:0]          rdata_d;

  reg                 hit_d;

  integer             i;

  // Shutdown gates every access except the function low bits and config
  wire shutdown   = low_power_select & ~start_q;

  wire wr_ok      = reg_wr & ~shutdown;

  wire rd_ok      = reg_rd & ~shutdown;

  wire refresh    = (refresh_cnt_q == 32'd0);

////////////////////////////////////////////////////////////////////////////////
// Result refresh

  always @(posedge sys_clk) begin
    if (rst) begin
      refresh_cnt_q <= 32'd0;
      volt_q        <= 40'h00_0000_0000;
      temp_q        <= 24'h00_0000;
      zone_temp     <= 24'h00_0000;
    end else begin
      if (refresh_cnt_q >= REFRESH_CYCLES - 1)
        refresh_cnt_q <= 32'd0;

      else
        refresh_cnt_q <= refresh_cnt_q + 32'd1;

      if (refresh) begin                                    // RL14

        volt_q <= volt_raw;                                 // RL12 RL13

        temp_q[7:0]   <= diode_fault[0] ? `TEMP_ERR :
                         sat_add(temp_raw[7:0], ofs_rmt1_q);    // RL11 RL16

        temp_q[15:8]  <= sat_add(temp_raw[15:8], ofs_amb_q);    // RL10 RL15

        temp_q[23:16] <= diode_fault[1] ? `TEMP_ERR :
                         sat_add(temp_raw[23:16], ofs_rmt2_q);  // RL11 RL16

      end

      // Zones trail the result registers by one cycle
      zone_temp <= temp_q;                                  // RL18

    end
  end

////////////////////////////////////////////////////////////////////////////////
// Writes

  always @(posedge sys_clk) begin
    if (rst) begin
      factory_test_q    <= `RST_ZERO;

      ofs_amb_q         <= `RST_ZERO;

      ofs_rmt2_q        <= `RST_ZERO;

      ofs_rmt1_q        <= `RST_ZERO;

      manual_duty       <= {3{`RST_DUTY}};

      start_q           <= 1'b0;

      lock_q            <= 1'b0;

      override_q        <= 1'b0;

      irq_output_enable <= 1'b0;

      low_power_select  <= 1'b0;

      sfr_low_q         <= 3'b000;

      sfr_high_q        <= `RST_ZERO;

      config_q          <= `RST_ZERO;

      for (i = 0; i < 3; i = i + 1)
        pwmopt_q[i] <= `RST_PWMOPT;

    end else begin
      // Function register low bits and config survive shutdown
      if (reg_wr && reg_addr == `ADDR_SFR) begin

        irq_output_enable <= reg_wdata[`SFR_IRQ_EN];        // RL4 RL5

        sfr_low_q         <= reg_wdata[2:0];

      end

      if (wr_ok && reg_addr == `ADDR_SFR && !lock_q)
        sfr_high_q <= reg_wdata;

      // Config is never locked, otherwise shutdown could not be left
      if (reg_wr && reg_addr == `ADDR_CONFIG) begin         // RL5

        config_q         <= reg_wdata;

        low_power_select <= reg_wdata[`CFG_LOW_POWER];

      end

      if (wr_ok) begin

        case (reg_addr)

          `ADDR_TEST: factory_test_q <= reg_wdata;          // RL8

          `ADDR_OFS_AMB: if (!lock_q) ofs_amb_q <= reg_wdata;   // RL9 RL10

          `ADDR_OFS_RMT2: if (!lock_q) ofs_rmt2_q <= reg_wdata; // RL9 RL11

          `ADDR_OFS_RMT1: if (!lock_q) ofs_rmt1_q <= reg_wdata; // RL9 RL11

          `ADDR_CTRL: begin
            override_q <= reg_wdata[`CTRL_OVERRIDE];        // RL2
            if (!lock_q) begin                              // RL2 RL19
              start_q <= reg_wdata[`CTRL_START];
              lock_q  <= reg_wdata[`CTRL_LOCK];
            end
          end
          default: begin
            if (reg_addr >= `ADDR_DUTY1 && reg_addr <= `ADDR_DUTY3 &&
                manual_mode[reg_addr[1:0]] && start_q && !lock_q)  // RL1
              manual_duty[reg_addr[1:0]*8 +: 8] <= reg_wdata;
            if (reg_addr >= `ADDR_PWMOPT1 && reg_addr <= `ADDR_PWMOPT3 && !lock_q)
              pwmopt_q[reg_addr[1:0] - 2'd0] <= reg_wdata;  // RL6
            // Other addresses dropped without error            RL7
          end
        endcase
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Reads and clear-on-read status

  always @* begin
    rdata_d = `RST_ZERO;
    hit_d   = 1'b1;
    case (reg_addr)
      `ADDR_TEST:     rdata_d = factory_test_q;

      `ADDR_OFS_AMB:  rdata_d = ofs_amb_q;

      `ADDR_OFS_RMT2: rdata_d = ofs_rmt2_q;

      `ADDR_OFS_RMT1: rdata_d = ofs_rmt1_q;

      `ADDR_V2V5:     rdata_d = volt_q[7:0];                // RL13

      `ADDR_VCORE:    rdata_d = volt_q[15:8];

      `ADDR_V3V3:     rdata_d = volt_q[23:16];

      `ADDR_V5V:      rdata_d = volt_q[31:24];

      `ADDR_V12V:     rdata_d = volt_q[39:32];

      `ADDR_T_RMT1:   rdata_d = temp_q[7:0];                // RL17

      `ADDR_T_AMB:    rdata_d = temp_q[15:8];

      `ADDR_T_RMT2:   rdata_d = temp_q[23:16];

      `ADDR_DUTY1:    rdata_d = manual_duty[7:0];

      `ADDR_DUTY2:    rdata_d = manual_duty[15:8];

      `ADDR_DUTY3:    rdata_d = manual_duty[23:16];

      `ADDR_CTRL:     rdata_d = {4'h0, override_q, 1'b0, lock_q, start_q};

      `ADDR_ISTAT1:   rdata_d = istat1_q;

      `ADDR_ISTAT2:   rdata_d = istat2_q;

      `ADDR_SFR:      rdata_d = {sfr_high_q[7:3], sfr_low_q};

      `ADDR_CONFIG:   rdata_d = config_q;

      8'h94:          rdata_d = pwmopt_q[0];                // RL6

      8'h95:          rdata_d = pwmopt_q[1];

      8'h96:          rdata_d = pwmopt_q[2];

      default: begin
        rdata_d = `RST_ZERO;                                // RL7
        hit_d   = 1'b0;
      end
    endcase
    // Shutdown hides everything but the function register low bits and config
    if (shutdown) begin                                     // RL5
      if (reg_addr == `ADDR_SFR)
        rdata_d = {5'b00000, sfr_low_q};
      else if (reg_addr != `ADDR_CONFIG)
        rdata_d = `RST_ZERO;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= `RST_ZERO;
      istat1_q  <= {NUM_EVT{1'b0}};
      istat2_q  <= {NUM_EVT{1'b0}};
    end else begin
      if (reg_rd)
        reg_rdata <= hit_d ? rdata_d : `RST_ZERO;

      // New events win over a clear in the same cycle
      if (rd_ok && reg_addr == `ADDR_ISTAT1 && evt1_in == {NUM_EVT{1'b0}})
        istat1_q <= evt1_in;                                // RL3

      else
        istat1_q <= istat1_q | evt1_in;

      if (rd_ok && reg_addr == `ADDR_ISTAT2 && evt2_in == {NUM_EVT{1'b0}})
        istat2_q <= evt2_in;                                // RL3

      else
        istat2_q <= istat2_q | evt2_in;

    end
  end

endmodule
`default_nettype wire

// file: src/hwmon_defs.vh
// Register offsets, field positions, reset values and timing counts of the monitor block
`ifndef HWMON_DEFS_VH
`define HWMON_DEFS_VH
`define ADDR_TEST        8'h10
`define ADDR_OFS_AMB     8'h1D
`define ADDR_OFS_RMT2    8'h1E
`define ADDR_OFS_RMT1    8'h1F
`define ADDR_V2V5        8'h20
`define ADDR_VCORE       8'h21
`define ADDR_V3V3        8'h22
`define ADDR_V5V         8'h23
`define ADDR_V12V        8'h24
`define ADDR_T_RMT1      8'h25
`define ADDR_T_AMB       8'h26
`define ADDR_T_RMT2      8'h27
`define ADDR_DUTY1       8'h30
`define ADDR_DUTY2       8'h31
`define ADDR_DUTY3       8'h32
`define ADDR_ISTAT1      8'h41
`define ADDR_ISTAT2      8'h42
`define ADDR_CTRL        8'h40
`define ADDR_PWMOPT1     8'h94
`define ADDR_PWMOPT3     8'h96
`define ADDR_SFR         8'h7C
`define ADDR_CONFIG      8'h7F
`define CTRL_START       0
`define CTRL_LOCK        1
`define CTRL_OVERRIDE    3
`define SFR_IRQ_EN       2
`define CFG_LOW_POWER    0
`define RST_ZERO         8'h00
`define RST_DUTY         8'hFF
`define RST_PWMOPT       8'h0C
`define TEMP_ERR         8'h80
`define TEMP_MAX         8'h7F
`define TEMP_MIN         8'h81
`define VOLT_NOMINAL     8'hC0
`define REFRESH_HZ       4
`define CLK_HZ           40000000
`define REFRESH_CYC      (`CLK_HZ / `REFRESH_HZ)
`endif

// file: dv/hwmon_regs_asserts.sv
// Port-level checks of the monitor register block
`timescale 1ns/100ps
`default_nettype none
module hwmon_regs_asserts #(
  parameter REFRESH_CYCLES = 16  // Result refresh period
) (
  input wire logic        sys_clk,           // Clock
  input wire logic        rst,               // Reset
  input wire logic        reg_wr,            // Write strobe
  input wire logic        reg_rd,            // Read strobe
  input wire logic [7:0]  reg_addr,          // Address
  input wire logic [7:0]  reg_wdata,         // Write data
  input wire logic [7:0]  reg_rdata,         // Read data
  input wire logic [1:0]  diode_fault,       // Diode faults
  input wire logic [2:0]  manual_mode,       // Manual modes
  input wire logic [23:0] manual_duty,       // Duties
  input wire logic        start_q,           // Start
  input wire logic        lock_q,            // Lock
  input wire logic        override_q,        // Override
  input wire logic        irq_output_enable, // Irq enable
  input wire logic        low_power_select   // Low power
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int flt_cnt;
  wire shut = low_power_select && !start_q;
  wire wr40 = reg_wr && reg_addr == 8'h40 && !shut;
  wire duty_ok = manual_mode[0] && start_q && !lock_q;
  // Fault must outlast a refresh before 80h is owed
  always @(posedge sys_clk) begin
    if (rst || !diode_fault[0]) flt_cnt <= 0;
    else if (flt_cnt < 255) flt_cnt <= flt_cnt + 1;
  end
  ////////////////////////////////////////////////////////////
  lock_hold_a: assert property (lock_q |=> lock_q) else $error("lock dropped");
  start_frozen_a: assert property (lock_q |=> $stable(start_q)) else $error("start moved");
  override_wr_a: assert property (wr40 |=> override_q == $past(reg_wdata[3]))
    else $error("override not written");
  lock_set_a: assert property (wr40 && !lock_q |=> lock_q == $past(reg_wdata[1]))
    else $error("lock not written");
  irq_en_wr_a: assert property (reg_wr && reg_addr == 8'h7C |=>
    irq_output_enable == $past(reg_wdata[2])) else $error("irq enable not written");
  cfg_wr_a: assert property (reg_wr && reg_addr == 8'h7F |=>
    low_power_select == $past(reg_wdata[0])) else $error("config not written");
  duty_wr_a: assert property (reg_wr && reg_addr == 8'h30 && duty_ok |=>
    manual_duty[7:0] == $past(reg_wdata)) else $error("duty not written");
  duty_block_a: assert property (reg_wr && reg_addr == 8'h30 && !duty_ok |=>
    $stable(manual_duty[7:0])) else $error("duty written when barred");
  undef_rd_a: assert property (reg_rd && reg_addr == 8'h50 |=> reg_rdata == 8'h00)
    else $error("undefined read not zero");
  fault_code_a: assert property (reg_rd && reg_addr == 8'h25 && !shut &&
    flt_cnt > REFRESH_CYCLES + 2 |=> reg_rdata == 8'h80) else $error("no fault code");
endmodule
`default_nettype wire

// file: dv/hwmon_host.sv
// Management-bus host model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module hwmon_host (
  input  wire logic       sys_clk,   // Clock
  output var  logic       reg_wr,    // Write strobe
  output var  logic       reg_rd,    // Read strobe
  output var  logic [7:0] reg_addr,  // Address
  output var  logic [7:0] reg_wdata  // Write data
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // Test register is never written, its effects are unsafe
    if (a != 8'h10) begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/hwmon_reading_offset_regs_tb.sv
// Self-checking bench for the monitor register block
`timescale 1ns/100ps
`default_nettype none
`include "hwmon_defs.vh"
module hwmon_reading_offset_regs_tb;
  localparam int REFRESH_CYCLES = 16;
  localparam logic [7:0] OA [3] = '{8'h1F, 8'h1D, 8'h1E};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [39:0] volt_raw = '0;
  logic [23:0] temp_raw = '0;
  logic [1:0] diode_fault = '0;
  logic [2:0] manual_mode = '0;
  logic [7:0] evt1_in = '0;
  logic [7:0] evt2_in = '0;
  wire reg_wr, reg_rd, start_q, lock_q, override_q, irq_output_enable, low_power_select;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, factory_test_q;
  wire [23:0] zone_temp, manual_duty;
  int num_errors = 0;
  int checked = 0;
  int i, r;
  integer seed = 32'hF711EEC7;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [39:0] vr;
  logic [7:0] tr[3], ofs[3], et[3];
  always #12.5 sys_clk = ~sys_clk;
  hwmon_regs #(.REFRESH_CYCLES(REFRESH_CYCLES), .NUM_EVT(8)) hwmon_regs_i (
    .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .volt_raw(volt_raw), .temp_raw(temp_raw),
    .diode_fault(diode_fault), .manual_mode(manual_mode), .evt1_in(evt1_in),
    .evt2_in(evt2_in), .zone_temp(zone_temp), .manual_duty(manual_duty), .start_q(start_q),
    .lock_q(lock_q), .override_q(override_q), .irq_output_enable(irq_output_enable),
    .low_power_select(low_power_select), .factory_test_q(factory_test_q));
  hwmon_host hwmon_host_i (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    hwmon_host_i.rd(a);
  endtask
  task automatic settle;
    @(negedge sys_clk);
  endtask
  function automatic logic [7:0] tsum(logic [7:0] t, logic [7:0] o, logic f);
    int s;
    s = $signed(t) + $signed(o);
    if (f) return 8'h80;
    if (s > 127) return 8'h7F;
    if (s < -127) return 8'h81;
    return s[7:0];
  endfunction
  task test_done;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (rd_d) check("rdata", reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  // Run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ADDR_TEST, 8'h00);
    for (i = 0; i < 3; i++) rd(OA[i], 8'h00);
    rd(`ADDR_PWMOPT1, `RST_PWMOPT);
    hwmon_host_i.wr(`ADDR_PWMOPT1, 8'hC0);
    rd(`ADDR_PWMOPT1, 8'hC0);
    hwmon_host_i.wr(8'h50, 8'hAA);
    rd(8'h50, 8'h00);
    for (r = 0; r < 2; r++) begin
      vr = r ? 40'hFFC000C0FF : 40'({$random(seed), $random(seed)});
      for (i = 0; i < 3; i++) begin
        tr[i] = (r && i == 1) ? 8'h7C : 8'($random(seed) % 100);
        ofs[i] = (r && i == 1) ? 8'h05 : 8'($random(seed) % 20);
        et[i] = tsum(tr[i], ofs[i], r && i != 1);
        hwmon_host_i.wr(OA[i], ofs[i]);
      end
      @(posedge sys_clk);
      volt_raw <= vr;
      temp_raw <= {tr[2], tr[1], tr[0]};
      diode_fault <= {r[0], r[0]};
      hwmon_host_i.wr(`ADDR_V2V5, 8'h55);
      repeat (2 * REFRESH_CYCLES + 4) @(posedge sys_clk);
      for (i = 0; i < 5; i++) rd(8'h20 + 8'(i), vr[8*i+:8]);
      for (i = 0; i < 3; i++) rd(8'h25 + 8'(i), et[i]);
      check("zone", zone_temp, {et[2], et[1], et[0]});
    end
    @(posedge sys_clk);
    evt1_in <= 8'h5A;
    evt2_in <= 8'hC3;
    repeat (2) @(posedge sys_clk);
    rd(`ADDR_ISTAT1, 8'h5A);
    rd(`ADDR_ISTAT1, 8'h5A);
    evt1_in <= 8'h00;
    evt2_in <= 8'h00;
    repeat (2) @(posedge sys_clk);
    rd(`ADDR_ISTAT1, 8'h5A);
    rd(`ADDR_ISTAT1, 8'h00);
    rd(`ADDR_ISTAT2, 8'hC3);
    rd(`ADDR_ISTAT2, 8'h00);
    hwmon_host_i.wr(`ADDR_CONFIG, 8'h01);
    hwmon_host_i.wr(`ADDR_OFS_RMT1, 8'h33);
    rd(`ADDR_OFS_RMT1, 8'h00);
    rd(`ADDR_CONFIG, 8'h01);
    hwmon_host_i.wr(`ADDR_CONFIG, 8'h00);
    rd(`ADDR_OFS_RMT1, ofs[0]);
    manual_mode <= 3'b001;
    hwmon_host_i.wr(`ADDR_DUTY1, 8'h40);
    settle;
    check("duty", manual_duty, 24'hFFFFFF);
    hwmon_host_i.wr(`ADDR_CTRL, 8'h01);
    hwmon_host_i.wr(`ADDR_DUTY1, 8'h40);
    hwmon_host_i.wr(`ADDR_DUTY2, 8'h20);
    hwmon_host_i.wr(`ADDR_CTRL, 8'h03);
    hwmon_host_i.wr(`ADDR_OFS_RMT1, 8'h77);
    rd(`ADDR_OFS_RMT1, ofs[0]);
    hwmon_host_i.wr(`ADDR_CTRL, 8'h08);
    hwmon_host_i.wr(`ADDR_DUTY1, 8'h10);
    hwmon_host_i.wr(`ADDR_SFR, 8'h04);
    settle;
    check("duty", manual_duty, 24'hFFFF40);
    check("ctrl", {override_q, lock_q, start_q, irq_output_enable}, 24'hF);
    check("test", factory_test_q, 24'h0);
    check("lowpwr", low_power_select, 24'h0);
    test_done;
  end
endmodule
bind hwmon_regs hwmon_regs_asserts #(.REFRESH_CYCLES(REFRESH_CYCLES)) hwmon_regs_asserts_i (
  .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .diode_fault(diode_fault),
  .manual_mode(manual_mode), .manual_duty(manual_duty), .start_q(start_q), .lock_q(lock_q),
  .override_q(override_q), .irq_output_enable(irq_output_enable),
  .low_power_select(low_power_select));
`default_nettype wire
